//--- rtl/arw_consts.vh
// timing constants for the converter read and wake sequencer
`ifndef ARW_CONSTS_VH
`define ARW_CONSTS_VH

`define ARW_CLK_NS        50
`define ARW_T_CNCS_NS     10
`define ARW_T_CSBSY_NS    40
`define ARW_T_CSCN_NS     10
`define ARW_T_RDPL_NS     15
`define ARW_T_RDPH_NS     15
`define ARW_T_OSHOLD_NS   20
`define ARW_T_RSTPH_NS    50
`define ARW_T_CYC_US      5
`define ARW_T_ACQ_US      1
`define ARW_T_STBYCN_US   100
`define ARW_T_RSTCN_US    25
`define ARW_T_SDINT_MS    50
`define ARW_T_SDEXT_MS    13

`define ARW_RSTPH_CYC  ((`ARW_T_RSTPH_NS + `ARW_CLK_NS - 1) / `ARW_CLK_NS)
`define ARW_CYC_CYC    ((`ARW_T_CYC_US * 1000 + `ARW_CLK_NS - 1) / `ARW_CLK_NS)
`define ARW_ACQ_CYC    ((`ARW_T_ACQ_US * 1000 + `ARW_CLK_NS - 1) / `ARW_CLK_NS)
`define ARW_STBYCN_CYC ((`ARW_T_STBYCN_US * 1000 + `ARW_CLK_NS - 1) / `ARW_CLK_NS)
`define ARW_RSTCN_CYC  ((`ARW_T_RSTCN_US * 1000 + `ARW_CLK_NS - 1) / `ARW_CLK_NS)
`define ARW_SDINT_CYC  ((`ARW_T_SDINT_MS * 1000000 + `ARW_CLK_NS - 1) / `ARW_CLK_NS)
`define ARW_SDEXT_CYC  ((`ARW_T_SDEXT_MS * 1000000 + `ARW_CLK_NS - 1) / `ARW_CLK_NS)

`define ARW_NUM_CHAN   8
`define ARW_OS_RST     3'h0

`endif

//--- rtl/arw_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module arw_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rstN,
  input  wire [WIDTH-1:0] pinIn,
  output reg  [WIDTH-1:0] levelOut
);
  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  genvar i;

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s1_q <= {WIDTH{1'b0}};
      s2_q <= {WIDTH{1'b0}};
      s3_q <= {WIDTH{1'b0}};
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once stages two and three agree
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gBit
      always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          levelOut[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          levelOut[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule // arw_sync

//--- rtl/arw_ctrl.v
// host sequencer: conversion start, parallel read windows, standby and shutdown exit
// Function
// - chip select low 10 ns after start
// - in-conversion read ends 40 ns before busy falls
// - after-conversion read waits for busy fall
// - chip select high 10 ns before start
// - chip select encloses every read strobe
// - oversample select stable around busy fall
// - wait 100 us after standby release
// - never use results before wake wait
// - wait 50 or 13 ms before reset
// - reset pulse high at least 50 ns
// - wait 25 us after reset falls
// - starts no closer than 5 us apart
`timescale 1ns/10ps
`include "arw_consts.vh"
module arw_ctrl #(
  parameter [19:0] SD_INT_CYC = `ARW_SDINT_CYC,
  parameter [19:0] SD_EXT_CYC = `ARW_SDEXT_CYC,
  parameter        NUM_CHAN   = `ARW_NUM_CHAN
) (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        convReq,
  input  wire        readAfter,
  input  wire [2:0]  osSel,
  input  wire        wakeReq,
  input  wire        shutdownSel,
  input  wire        intRef,
  output wire        ready,
  output reg         sampleValid_q,
  output reg  [15:0] sampleData_q,
  output reg  [2:0]  sampleChan_q,
  output reg         sampleFirst_q,
  output reg         conv_start_a,
  output reg         conv_start_b,
  output reg         csN_q,
  output reg         rdN_q,
  output reg         adcReset_q,
  output reg         standby_n,
  output reg  [2:0]  oversample_select,
  input  wire        busy,
  input  wire [15:0] parallel_data_bus,
  input  wire        first_channel_flag
);
  localparam [3:0] ST_RSTP  = 4'h0;
  localparam [3:0] ST_RWAIT = 4'h1;
  localparam [3:0] ST_IDLE  = 4'h2;
  localparam [3:0] ST_CONV  = 4'h3;
  localparam [3:0] ST_BSYH  = 4'h4;
  localparam [3:0] ST_BSYL  = 4'h5;
  localparam [3:0] ST_CSLO  = 4'h6;
  localparam [3:0] ST_RDLO  = 4'h7;
  localparam [3:0] ST_RDHI  = 4'h8;
  localparam [3:0] ST_CSHI  = 4'h9;
  localparam [3:0] ST_SLEEP = 4'ha;
  localparam [3:0] ST_WAKE  = 4'hb;

  localparam [31:0] STANDBY_N_W    = `ARW_STBYCN_CYC;
  localparam [31:0] RSTCN_W   = `ARW_RSTCN_CYC;
  localparam [31:0] RSTPH_W   = `ARW_RSTPH_CYC;
  localparam [31:0] CYC_W     = `ARW_CYC_CYC;
  localparam [31:0] ACQ_W     = `ARW_ACQ_CYC;
  localparam [31:0] LAST_W    = NUM_CHAN - 1;
  // counts cut to counter width on purpose
  localparam [19:0] STANDBY_N_CYC  = STANDBY_N_W[19:0];
  localparam [19:0] RSTCN_CYC = RSTCN_W[19:0];
  localparam [19:0] RSTPH_CYC = RSTPH_W[19:0];
  localparam [6:0]  CYC_CYC   = CYC_W[6:0];
  localparam [6:0]  ACQ_CYC   = ACQ_W[6:0];
  localparam [2:0]  LAST_CHAN = LAST_W[2:0];

  reg        rs1_q;
  reg        rs2_q;
  wire       rstN;
  wire       busyS;
  reg [3:0]  state_q;
  reg [19:0] waitCnt_q;
  reg [6:0]  spaceCnt_q;
  reg        after_q;
  reg        shut_q;
  reg [2:0]  chan_q;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end
  assign rstN = rs2_q;

  arw_sync #(
    .WIDTH (1)
  ) uBusySync (
    .clk      (clk_sys),
    .rstN     (rstN),
    .pinIn    (busy),
    .levelOut (busyS)
  );

  // refuse starts until wake waits end
  assign ready = (state_q == ST_IDLE) && (spaceCnt_q == 7'h00) && wakeReq;

  always @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      state_q           <= ST_RSTP;
      waitCnt_q         <= 20'h00000;
      spaceCnt_q        <= 7'h00;
      after_q           <= 1'b0;
      shut_q            <= 1'b0;
      chan_q            <= 3'h0;
      conv_start_a      <= 1'b0;
      conv_start_b      <= 1'b0;
      csN_q             <= 1'b1;
      rdN_q             <= 1'b1;
      adcReset_q        <= 1'b1;
      standby_n         <= 1'b1;
      oversample_select <= `ARW_OS_RST;
      sampleValid_q     <= 1'b0;
      sampleData_q      <= 16'h0000;
      sampleChan_q      <= 3'h0;
      sampleFirst_q     <= 1'b0;
    end else begin
      sampleValid_q <= 1'b0;
      if (spaceCnt_q != 7'h00) begin
        spaceCnt_q <= spaceCnt_q - 7'h01;
      end
      case (state_q)
        ST_RSTP: begin
          if (waitCnt_q + 20'h00001 >= RSTPH_CYC) begin
            adcReset_q <= 1'b0;
            waitCnt_q  <= RSTCN_CYC;
            state_q    <= ST_RWAIT;
          end else begin
            waitCnt_q <= waitCnt_q + 20'h00001;
          end
        end
        ST_RWAIT: begin
          if (waitCnt_q <= 20'h00001) begin
            waitCnt_q <= 20'h00000;
            state_q   <= ST_IDLE;
          end else begin
            waitCnt_q <= waitCnt_q - 20'h00001;
          end
        end
        ST_IDLE: begin
          if (!wakeReq) begin
            standby_n <= 1'b0;
            state_q   <= ST_SLEEP;
          end else if (convReq && (spaceCnt_q == 7'h00)) begin
            oversample_select <= osSel;
            after_q      <= readAfter;
            conv_start_a <= 1'b1;
            conv_start_b <= 1'b1;
            spaceCnt_q <= CYC_CYC;
            state_q    <= ST_CONV;
          end
        end
        ST_CONV: begin
          conv_start_a <= 1'b0;
          conv_start_b <= 1'b0;
          // one full cycle after start edge
          if (after_q) begin
            state_q <= ST_BSYH;
          end else begin
            csN_q   <= 1'b0;
            state_q <= ST_CSLO;
          end
        end
        ST_BSYH: begin
          if (busyS) begin
            state_q <= ST_BSYL;
          end
        end
        ST_BSYL: begin
          if (!busyS) begin
            if (spaceCnt_q < ACQ_CYC) begin
              spaceCnt_q <= ACQ_CYC;
            end
            // chip select only after busy fell
            if (after_q) begin
              csN_q   <= 1'b0;
              state_q <= ST_CSLO;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_CSLO: begin
          rdN_q   <= 1'b0;
          chan_q  <= 3'h0;
          state_q <= ST_RDLO;
        end
        ST_RDLO: begin
          // bus is stable while strobe low, so no synchroniser here
          rdN_q         <= 1'b1;
          sampleData_q  <= parallel_data_bus;
          sampleFirst_q <= first_channel_flag;
          sampleChan_q  <= chan_q;
          sampleValid_q <= 1'b1;
          state_q       <= ST_RDHI;
        end
        ST_RDHI: begin
          if (chan_q == LAST_CHAN) begin
            csN_q   <= 1'b1;
            state_q <= ST_CSHI;
          end else begin
            chan_q  <= chan_q + 3'h1;
            rdN_q   <= 1'b0;
            state_q <= ST_RDLO;
          end
        end
        ST_CSHI: begin
          // short burst ends far before busy falls
          // idle cycle before any new start
          if (after_q) begin
            state_q <= ST_IDLE;
          end else begin
            state_q <= ST_BSYH;
          end
        end
        ST_SLEEP: begin
          if (wakeReq) begin
            standby_n <= 1'b1;
            shut_q    <= shutdownSel;
            if (shutdownSel) begin
              waitCnt_q <= intRef ? SD_INT_CYC : SD_EXT_CYC;
            end else begin
              waitCnt_q <= STANDBY_N_CYC;
            end
            state_q <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (waitCnt_q <= 20'h00001) begin
            if (shut_q) begin
              adcReset_q <= 1'b1;
              waitCnt_q  <= 20'h00000;
              state_q    <= ST_RSTP;
            end else begin
              waitCnt_q <= 20'h00000;
              state_q   <= ST_IDLE;
            end
          end else begin
            waitCnt_q <= waitCnt_q - 20'h00001;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // arw_ctrl

//--- sim/arw_ctrl_sva.sv
// port checker for the converter sequencer
`timescale 1ns/10ps
module arw_ctrl_chk #(
  parameter [19:0] SD_INT_CYC = 20'h0,
  parameter [19:0] SD_EXT_CYC = 20'h0,
  parameter        NUM_CHAN   = 8
) (
  input wire       clk_sys,
  input wire       nrst,
  input wire       conv_start_a,
  input wire       csN_q,
  input wire       rdN_q,
  input wire       adcReset_q,
  input wire       standby_n,
  input wire       intRef,
  input wire [2:0] oversample_select,
  input wire       busy
);
  reg [6:0]  gapQ;
  reg [8:0]  rstQ;
  reg [19:0] stbQ;
  reg        seenQ;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // saturating counts since start, reset fall and wake
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gapQ  <= 7'h7f;
      rstQ  <= 9'h0;
      stbQ  <= 20'hfffff;
      seenQ <= 1'b0;
    end else begin
      gapQ  <= conv_start_a ? 7'h0 : gapQ + {6'h0, gapQ != 7'h7f};
      rstQ  <= adcReset_q ? 9'h0 : rstQ + {8'h0, rstQ != 9'h1ff};
      stbQ  <= !standby_n ? 20'h0 : stbQ + {19'h0, stbQ != 20'hfffff};
      seenQ <= standby_n & (seenQ | adcReset_q);
    end
  end
  conv_gap_a: assert property (conv_start_a |-> gapQ >= 7'd99) else $error("start spacing short");
  cs_before_conv_a: assert property (conv_start_a |-> csN_q && $past(csN_q)) else $error("cs low at start");
  cs_after_conv_a: assert property ($fell(csN_q) |-> !conv_start_a) else $error("cs fell with start");
  cs_busy_gap_a: assert property ($fell(busy) |-> csN_q && $past(csN_q)) else $error("cs low at busy fall");
  rd_in_cs_a: assert property (!rdN_q |-> !csN_q ##1 !csN_q) else $error("strobe outside cs");
  os_stable_a: assert property ($past(busy) |-> $stable(oversample_select)) else $error("os moved");
  standby_n_wait_a: assert property (conv_start_a |-> stbQ >= 20'd2000 || seenQ) else $error("wake wait short");
  sd_wait_a: assert property ($rose(adcReset_q) |-> stbQ >= (intRef ? SD_INT_CYC : SD_EXT_CYC))
    else $error("reset early");
  rst_wait_a: assert property (conv_start_a |-> rstQ >= 9'd500) else $error("start after reset early");
  cover property ($fell(busy) ##[1:8] $fell(csN_q));
  cover property (!rdN_q && busy);
  cover property ($rose(adcReset_q));
endmodule // arw_ctrl_chk
bind arw_ctrl arw_ctrl_chk #(.SD_INT_CYC(SD_INT_CYC), .SD_EXT_CYC(SD_EXT_CYC), .NUM_CHAN(NUM_CHAN)) chk (
  .clk_sys(clk_sys), .nrst(nrst), .conv_start_a(conv_start_a), .csN_q(csN_q), .rdN_q(rdN_q),
  .adcReset_q(adcReset_q), .standby_n(standby_n), .intRef(intRef), .oversample_select(oversample_select),
  .busy(busy));

//--- sim/arw_dev_model.sv
// behavioural converter: busy, channel words, first-channel flag
`timescale 1ns/10ps
module arw_dev_model (
  input  wire        clk,
  input  wire        convA,
  input  wire        csN,
  input  wire        rdN,
  input  wire [2:0]  os,
  output reg         busy = 1'b0,
  output wire [15:0] db,
  output wire        first
);
  reg [12:0] left   = 13'h0;
  reg [2:0]  idx    = 3'h0;
  reg [2:0]  osLat  = 3'h0;
  reg        rdPrev = 1'b1;
  reg [15:0] junk   = 16'h0;
  // busy spans the conversion, longer with oversampling
  always @(posedge clk) begin
    rdPrev <= rdN;
    junk   <= ~junk;
    if (convA) begin
      busy <= 1'b1;
      left <= 13'd76 << osLat;
      idx  <= 3'h0;
    end else if (left != 13'h0) begin
      left <= left - 13'h1;
      if (left == 13'h1) begin
        busy  <= 1'b0;
        osLat <= os;
      end
    end
    if (!csN && !rdPrev && rdN)
      idx <= idx + 3'h1;
  end
  // released bus shows a moving pattern, not the last word
  assign db    = (!csN && !rdN) ? {13'h0b40, idx} : junk;
  assign first = (!csN && !rdN) ? (idx == 3'h0) : junk[0];
endmodule // arw_dev_model

//--- sim/arw_ctrl_test.sv
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
module arw_ctrl_test;
  reg         clk_sys = 1'b0;
  reg         nrst = 1'b0;
  reg         convReq = 1'b0;
  reg         readAfter = 1'b0;
  reg  [2:0]  osSel = 3'h0;
  reg         wakeReq = 1'b1;
  reg         shutdownSel = 1'b0;
  reg         intRef = 1'b0;
  wire        ready, sampleValid_q, sampleFirst_q, conv_start_a, csN_q, rdN_q, adcReset_q, standby_n, busy, first;
  wire        conv_start_b;
  wire [15:0] sampleData_q, db;
  wire [2:0]  sampleChan_q, oversample_select;
  integer     n_errors = 0;
  integer     comparisons = 0;
  integer     i, k, t;
  // row: expected busy at first word, read-after, oversample code
  reg  [4:0]  rows [0:3];
  initial forever #25 clk_sys = ~clk_sys;
  arw_ctrl #(.SD_INT_CYC(20'd40), .SD_EXT_CYC(20'd30)) uut (.clk_sys(clk_sys), .nrst(nrst), .convReq(convReq),
    .readAfter(readAfter), .osSel(osSel), .wakeReq(wakeReq), .shutdownSel(shutdownSel), .intRef(intRef),
    .ready(ready), .sampleValid_q(sampleValid_q), .sampleData_q(sampleData_q), .sampleChan_q(sampleChan_q),
    .sampleFirst_q(sampleFirst_q), .conv_start_a(conv_start_a), .conv_start_b(conv_start_b), .csN_q(csN_q),
    .rdN_q(rdN_q),
    .adcReset_q(adcReset_q), .standby_n(standby_n), .oversample_select(oversample_select), .busy(busy),
    .parallel_data_bus(db), .first_channel_flag(first));
  arw_dev_model dev (.clk(clk_sys), .convA(conv_start_a), .csN(csN_q), .rdN(rdN_q), .os(oversample_select),
    .busy(busy), .db(db), .first(first));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks=%0d errors=%0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // bounded wait: 0 ready, 1 word, 2 asleep, 3 reset pulse
  task spin(input [1:0] m, input integer lim);
    begin
      t = 0;
      while (!(m == 0 ? ready === 1'b1 : m == 1 ? sampleValid_q === 1'b1 : m == 2 ? standby_n === 1'b0
               : adcReset_q === 1'b1) && t < lim) begin
        @(negedge clk_sys);
        t = t + 1;
      end
      if (t >= lim) begin
        check(32'h1, 32'h0);
        conclude;
      end
    end
  endtask
  task convert(input [4:0] row);
    begin
      spin(0, 5000);
      @(posedge clk_sys);
      readAfter <= row[3];
      osSel <= row[2:0];
      convReq <= 1'b1;
      @(posedge clk_sys);
      convReq <= 1'b0;
      @(negedge clk_sys);
      check({conv_start_a, conv_start_b, oversample_select}, {2'b11, row[2:0]});
      for (k = 0; k < 8; k = k + 1) begin
        spin(1, 400);
        if (k == 0) check(busy, row[4]);
        check({sampleFirst_q, sampleChan_q, sampleData_q}, {k == 0, k[2:0], 16'h5a00 + k[15:0]});
        @(negedge clk_sys);
      end
    end
  endtask
  initial begin
    rows[0] = 5'h10;
    rows[1] = 5'h08;
    rows[2] = 5'h11;
    rows[3] = 5'h09;
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    check({csN_q, rdN_q, adcReset_q, ready, standby_n}, 5'h1d);
    @(posedge clk_sys);
    nrst <= 1'b1;
    spin(0, 700);
    check(t >= 500, 1);
    for (i = 0; i < 4; i = i + 1) begin
      convert(rows[i]);
      $display("row %0d done", i);
    end
    // request while spacing runs must vanish
    @(posedge clk_sys);
    convReq <= 1'b1;
    @(posedge clk_sys);
    convReq <= 1'b0;
    t = 0;
    for (k = 0; k < 40; k = k + 1) begin
      @(negedge clk_sys);
      t = t + conv_start_a;
    end
    check(t, 0);
    $display("refusal done");
    spin(0, 500);
    @(posedge clk_sys);
    wakeReq <= 1'b0;
    spin(2, 10);
    @(posedge clk_sys);
    wakeReq <= 1'b1;
    spin(0, 3000);
    check(t >= 2000, 1);
    convert(5'h10);
    $display("standby done");
    for (i = 0; i < 2; i = i + 1) begin
      spin(0, 500);
      @(posedge clk_sys);
      wakeReq <= 1'b0;
      shutdownSel <= 1'b1;
      intRef <= i[0];
      spin(2, 10);
      @(posedge clk_sys);
      wakeReq <= 1'b1;
      spin(3, 200);
      check(t >= (i ? 40 : 30), 1);
      spin(0, 700);
      check(t >= 500, 1);
      convert(5'h08);
      $display("shutdown %0d done", i);
    end
    conclude;
  end
endmodule // arw_ctrl_test
